// >>> alu_branch_pkg.sv
// Purpose: Shared constants and types for the byte ALU and branch decoder.
// Assumes: APB register offsets are byte addresses, one 32-bit word each.
// Notes: Status flag order in flags_s matches the STATUS register bits.
package alu_branch_pkg;
   // Register byte offsets on the APB bus.
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_INSTR = 8'h04;
   localparam logic [7:0] OFF_WREG = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_BANK = 8'h10;
   localparam logic [7:0] OFF_INDEX = 8'h14;
   localparam logic [7:0] OFF_FILE_IN = 8'h18;
   localparam logic [7:0] OFF_FILE_OUT = 8'h1C;
   localparam logic [7:0] OFF_FILE_ADDR = 8'h20;
   localparam logic [7:0] OFF_PC = 8'h24;
   localparam logic [7:0] OFF_STATE = 8'h28;
   // Field positions.
   localparam int CTRL_EXT_BIT = 0;
   localparam int FADDR_WR_BIT = 12;
   localparam int STATE_BUSY_BIT = 0;
   localparam int STATE_TAKEN_BIT = 1;
   localparam int STATE_Q_LSB = 4;
   // Opcode patterns, compared against the named upper bits of the word.
   localparam logic [5:0] OP_ADD_ACC_TO_FILE = 6'h09;
   localparam logic [5:0] OP_ADD_WITH_CARRY = 6'h08;
   localparam logic [5:0] OP_AND_ACC_WITH_FILE = 6'h05;
   localparam logic [7:0] OP_AND_IMMEDIATE = 8'h0B;
   localparam logic [3:0] OP_CLEAR_FILE_BIT = 4'h9;
   localparam logic [7:0] OP_BRANCH_ON_CARRY = 8'hE2;
   localparam logic [7:0] OP_BRANCH_NO_CARRY = 8'hE3;
   localparam logic [7:0] OP_BRANCH_NO_WRAP = 8'hE5;
   localparam logic [7:0] OP_BRANCH_ON_SIGN = 8'hE6;
   localparam logic [7:0] OP_BRANCH_SIGN_CLEAR = 8'hE7;
   // Addressing constants.
   localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
   localparam logic [3:0] SPECIAL_BANK = 4'hF;
   // Timing: four clock phases per instruction cycle.
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam logic [20:0] PC_STEP = 21'h000002;
   // Execution states, Gray coded along idle, execute, idle slot.
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_EXEC = 2'h1,
      ST_NOP = 2'h3
   } exec_e;
   // Arithmetic flags, bit 4 down to bit 0.
   typedef struct packed {
      logic n;
      logic wrap;
      logic z;
      logic half_c;
      logic c;
   } flags_s;
endpackage

// >>> byte_adder.sv
// Purpose: Eight-bit adder with carry, half carry and signed wrap outputs.
// Assumes: Purely combinational; the caller registers the results.
// Notes: Carry in is zero for the plain add form.
`timescale 1ns/1ps
module byte_adder (
   // Operands.
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   // Results.
   output logic [7:0] sum,
   output logic cout,
   output logic hcout,
   output logic ovf
);
   logic [4:0] low_sum; // Low nibble sum, bit 4 is the half carry.
   logic [8:0] full_sum; // Full sum, bit 8 is the carry.

   // Nibble and byte sums share the same carry in.
   assign low_sum = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, cin};
   assign full_sum = {1'h0, a} + {1'h0, b} + {8'h00, cin};
   assign sum = full_sum[7:0];
   assign cout = full_sum[8];
   assign hcout = low_sum[4];
   // Signed wrap: like-signed operands giving a result of the other sign.
   assign ovf = (a[7] == b[7]) && (full_sum[7] != a[7]);
endmodule

// >>> branch_target.sv
// Purpose: Next sequential address and relative branch target.
// Assumes: Program addresses are byte addresses of 16-bit words.
// Notes: The offset counts words, so it is doubled before the add.
`timescale 1ns/1ps
module branch_target
   import alu_branch_pkg::*;
(
   // Current instruction address and signed word offset.
   input wire logic [20:0] pc,
   input wire logic [7:0] offset,
   // Results.
   output logic [20:0] next_pc,
   output logic [20:0] target
);
   logic [20:0] disp; // Sign-extended, doubled offset.

   // The counter is stepped past the branch word here, then the offset is added.
   assign disp = {{12{offset[7]}}, offset, 1'h0}; // RULE_08
   assign next_pc = pc + PC_STEP;
   assign target = next_pc + disp;
endmodule

// >>> byte_alu_and_branch_decode.sv
// Purpose: Executes the byte add, AND, bit clear and flag branch forms.
// Assumes: Software feeds the file operand and reads the file result.
// Notes: One instruction cycle is four clocks; a taken branch adds four.
// What this block does
// RULE_01 - Destination bit picks accumulator or file
// RULE_02 - Access bit picks access or selected bank
// RULE_03 - Extended mode indexes low access addresses
// RULE_04 - Add accumulator to file, set flags
// RULE_05 - Add with carry, route, set flags
// RULE_06 - Taken target is address plus two plus offset
// RULE_07 - Branch: one cycle, taken two with idle
// RULE_08 - Offset signed byte, doubled before adding
// RULE_09 - Branch when negative flag set
// RULE_10 - Branch when signed wrap clear
// RULE_11 - Carry set, carry clear, negative clear branches
// RULE_12 - AND forms set N, Z; clear bit
`timescale 1ns/1ps
module byte_alu_and_branch_decode
   import alu_branch_pkg::*;
(
   // Clock, reset and clock enable.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB request.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   // APB answer.
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // Whole state of the block in one record.
   typedef struct packed {
      exec_e st;
      logic [1:0] q;
      logic ext_en;
      logic [15:0] instr;
      logic [7:0] wreg;
      flags_s fl;
      logic [3:0] bank_sel;
      logic [11:0] fsr2;
      logic [7:0] file_in;
      logic [7:0] file_out;
      logic [11:0] file_addr;
      logic file_wr;
      logic [20:0] pc;
      logic taken;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_s;

   localparam state_s RST_STATE = '0; // Everything clear, idle, address zero.

   state_s r_reg; // Registered state.
   state_s r_next; // Next state.

   // Instruction fields.
   logic [7:0] f; // File address or literal or offset.
   logic d; // Destination select.
   logic a; // Access select.
   logic [2:0] bit_sel; // Bit number for the bit clear form.
   logic is_add; // Plain add.
   logic is_addc; // Add with carry.
   logic is_and_file; // AND with file.
   logic is_and_imm; // AND with literal.
   logic is_bit_clr; // Bit clear.
   logic is_byte; // Byte form with destination bit.
   logic is_file; // Any form that addresses a file register.
   logic br_hit; // A supported branch opcode.
   logic take; // Branch condition holds.
   logic [11:0] eaddr; // Effective file address.
   logic [7:0] sum; // Adder result.
   logic cout; // Adder carry.
   logic hcout; // Adder half carry.
   logic ovf; // Adder signed wrap.
   logic [7:0] res; // Selected result byte.
   logic [20:0] next_pc; // Sequential address.
   logic [20:0] tgt; // Branch target.
   logic commit; // Last phase of the execute cycle.
   logic busy; // An instruction is in flight.
   logic access; // APB access phase.
   logic [31:0] rd_val; // Read data for the current address.
   logic addr_ok; // Address is mapped.

   // Field split of the held instruction word.
   assign f = r_reg.instr[7:0];
   assign d = r_reg.instr[9];
   assign a = r_reg.instr[8];
   assign bit_sel = r_reg.instr[11:9];
   assign is_add = r_reg.instr[15:10] == OP_ADD_ACC_TO_FILE;
   assign is_addc = r_reg.instr[15:10] == OP_ADD_WITH_CARRY;
   assign is_and_file = r_reg.instr[15:10] == OP_AND_ACC_WITH_FILE;
   assign is_and_imm = r_reg.instr[15:8] == OP_AND_IMMEDIATE;
   assign is_bit_clr = r_reg.instr[15:12] == OP_CLEAR_FILE_BIT;
   assign is_byte = is_add || is_addc || is_and_file;
   assign is_file = is_byte || is_bit_clr;
   assign commit = ce && (r_reg.st == ST_EXEC) && (r_reg.q == Q_LAST);
   assign busy = r_reg.st != ST_IDLE;
   assign access = psel && penable;

   // Branch condition per opcode; unknown opcodes never branch.
   always_comb begin
      br_hit = 1'h1;
      take = 1'h0;
      case (r_reg.instr[15:8])
         OP_BRANCH_ON_CARRY: take = r_reg.fl.c; // RULE_11
         OP_BRANCH_NO_CARRY: take = !r_reg.fl.c; // RULE_11
         OP_BRANCH_ON_SIGN: take = r_reg.fl.n; // RULE_09
         OP_BRANCH_SIGN_CLEAR: take = !r_reg.fl.n; // RULE_11
         OP_BRANCH_NO_WRAP: take = !r_reg.fl.wrap; // RULE_10
         default: br_hit = 1'h0;
      endcase
   end

   // Effective address: indexed, access bank or selected bank.
   always_comb begin
      if (!a && r_reg.ext_en && (f <= ACCESS_SPLIT)) begin
         eaddr = r_reg.fsr2 + {4'h0, f}; // RULE_03
      end else if (!a) begin
         // Low access half maps to bank 0, high half to the special bank.
         eaddr = (f <= ACCESS_SPLIT) ? {4'h0, f} : {SPECIAL_BANK, f}; // RULE_02
      end else begin
         eaddr = {r_reg.bank_sel, f}; // RULE_02
      end
   end

   // Adder; the carry flag only enters for the carry form.
   byte_adder byte_adder_inst (
      .a(r_reg.wreg),
      .b(r_reg.file_in),
      .cin(is_addc && r_reg.fl.c), // RULE_05
      .sum(sum),
      .cout(cout),
      .hcout(hcout),
      .ovf(ovf)
   );

   // Target address from the current instruction address.
   branch_target branch_target_inst (
      .pc(r_reg.pc),
      .offset(f),
      .next_pc(next_pc),
      .target(tgt)
   );

   // Result byte for the executing form.
   always_comb begin
      if (is_add || is_addc) begin
         res = sum; // RULE_04
      end else if (is_and_imm) begin
         res = r_reg.wreg & f; // RULE_12
      end else if (is_and_file) begin
         res = r_reg.wreg & r_reg.file_in; // RULE_12
      end else begin
         res = r_reg.file_in & ~(8'h01 << bit_sel); // RULE_12
      end
   end

   // Register map; unmapped addresses read zero and flag an error.
   always_comb begin
      rd_val = 32'h00000000;
      addr_ok = 1'h1;
      case (paddr)
         OFF_CTRL: rd_val[CTRL_EXT_BIT] = r_reg.ext_en;
         OFF_INSTR: rd_val[15:0] = r_reg.instr;
         OFF_WREG: rd_val[7:0] = r_reg.wreg;
         OFF_STATUS: rd_val[4:0] = r_reg.fl;
         OFF_BANK: rd_val[3:0] = r_reg.bank_sel;
         OFF_INDEX: rd_val[11:0] = r_reg.fsr2;
         OFF_FILE_IN: rd_val[7:0] = r_reg.file_in;
         OFF_FILE_OUT: rd_val[7:0] = r_reg.file_out;
         OFF_FILE_ADDR: rd_val[FADDR_WR_BIT:0] = {r_reg.file_wr, r_reg.file_addr};
         OFF_PC: rd_val[20:0] = r_reg.pc;
         OFF_STATE: begin
            rd_val[STATE_BUSY_BIT] = busy;
            rd_val[STATE_TAKEN_BIT] = r_reg.taken;
            rd_val[STATE_Q_LSB +: 2] = r_reg.q;
         end
         default: addr_ok = 1'h0;
      endcase
   end

   // Next state: execution sequence and APB slave.
   always_comb begin
      r_next = r_reg;
      // Phase counter runs while an instruction or its idle slot is live.
      case (r_reg.st)
         ST_EXEC: begin
            r_next.q = r_reg.q + 2'h1;
            if (r_reg.q == Q_LAST) begin
               // Final phase: write results, flags and the counter.
               r_next.taken = br_hit && take;
               r_next.pc = (br_hit && take) ? tgt : next_pc; // RULE_06
               r_next.st = (br_hit && take) ? ST_NOP : ST_IDLE; // RULE_07
               if (is_file) begin
                  r_next.file_addr = eaddr;
               end
               if (is_and_imm || (is_byte && !d)) begin
                  r_next.wreg = res; // RULE_01
               end else if (is_file) begin
                  // Bit clear always writes back to the file register.
                  r_next.file_out = res; // RULE_01
                  r_next.file_wr = 1'h1;
               end
               if (is_add || is_addc) begin
                  r_next.fl = '{n: sum[7], wrap: ovf, z: sum == 8'h00, half_c: hcout,
                                c: cout}; // RULE_04
               end else if (is_and_imm || is_and_file) begin
                  // Only sign and zero change for the AND forms.
                  r_next.fl.n = res[7]; // RULE_12
                  r_next.fl.z = res == 8'h00; // RULE_12
               end
            end
         end
         ST_NOP: begin
            // Second cycle of a taken branch does nothing in any phase.
            r_next.q = r_reg.q + 2'h1;
            if (r_reg.q == Q_LAST) begin
               r_next.st = ST_IDLE; // RULE_07
            end
         end
         ST_IDLE: r_next.q = 2'h0;
         default: r_next.st = ST_IDLE;
      endcase
      // APB: answer one cycle into the access phase, act when it completes.
      if (access && !r_reg.pready) begin
         r_next.pready = 1'h1;
         r_next.prdata = pwrite ? 32'h00000000 : rd_val;
         // Writes other than control are refused while busy, avoiding a clash
         // with the result write of the final phase.
         r_next.pslverr = !addr_ok || (pwrite && busy && (paddr != OFF_CTRL));
      end else if (access && r_reg.pready) begin
         r_next.pready = 1'h0;
         r_next.pslverr = 1'h0;
         if (pwrite && !r_reg.pslverr) begin
            case (paddr)
               OFF_CTRL: r_next.ext_en = pwdata[CTRL_EXT_BIT];
               OFF_INSTR: begin
                  // Issuing an instruction starts a fresh execute cycle.
                  r_next.instr = pwdata[15:0];
                  r_next.st = ST_EXEC;
                  r_next.q = 2'h0;
                  r_next.file_wr = 1'h0;
                  r_next.taken = 1'h0;
               end
               OFF_WREG: r_next.wreg = pwdata[7:0];
               OFF_STATUS: r_next.fl = pwdata[4:0];
               OFF_BANK: r_next.bank_sel = pwdata[3:0];
               OFF_INDEX: r_next.fsr2 = pwdata[11:0];
               OFF_FILE_IN: r_next.file_in = pwdata[7:0];
               OFF_PC: r_next.pc = pwdata[20:0];
               default: r_next.file_wr = r_reg.file_wr;
            endcase
         end
      end else begin
         r_next.pready = 1'h0;
         r_next.pslverr = 1'h0;
      end
   end

   // State register; a low clock enable freezes everything.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= RST_STATE;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // A taken branch followed by a four-phase idle cycle.
   sequence s_taken_commit;
      commit && br_hit && take;
   endsequence
   sequence s_idle_slot;
      (r_reg.st == ST_NOP)[*4] ##1 (r_reg.st == ST_IDLE);
   endsequence

   AST_DEST_FILE: assert property ( // RULE_01
      commit && is_byte && d |=> r_reg.file_wr && (r_reg.wreg == $past(r_reg.wreg)))
      else $error("Result to file changed the accumulator.");
   AST_DEST_ACC: assert property ( // RULE_01
      commit && is_byte && !d |=> !r_reg.file_wr && (r_reg.wreg == $past(res)))
      else $error("Result to accumulator misrouted.");
   AST_BANK: assert property ( // RULE_02
      commit && is_file && a |=> r_reg.file_addr == {$past(r_reg.bank_sel), $past(f)})
      else $error("Banked address wrong.");
   AST_INDEXED: assert property ( // RULE_03
      commit && is_file && !a && r_reg.ext_en && (f <= ACCESS_SPLIT)
      |=> r_reg.file_addr == $past(r_reg.fsr2) + {4'h0, $past(f)})
      else $error("Indexed address wrong.");
   AST_ADD: assert property ( // RULE_04
      commit && is_add && !d
      |=> {r_reg.fl.c, r_reg.wreg} == $past({1'h0, r_reg.wreg} + {1'h0, r_reg.file_in}))
      else $error("Add result or carry wrong.");
   AST_ADDC: assert property ( // RULE_05
      commit && is_addc && !d
      |=> {r_reg.fl.c, r_reg.wreg} == $past({1'h0, r_reg.wreg} + {1'h0, r_reg.file_in}
                                            + {8'h00, r_reg.fl.c}))
      else $error("Add with carry result wrong.");
   AST_TARGET: assert property ( // RULE_06
      s_taken_commit |=> r_reg.pc == $past(r_reg.pc) + PC_STEP
                                    + {{12{$past(f[7])}}, $past(f), 1'h0})
      else $error("Branch target wrong.");
   AST_BACKWARD: assert property ( // RULE_08
      s_taken_commit and f[7] && (r_reg.pc > 21'h000200)
      |=> r_reg.pc < $past(r_reg.pc) + PC_STEP)
      else $error("Negative offset did not branch back.");
   AST_TAKEN_SLOT: assert property (@(posedge pclk) disable iff (!presetn || !ce) // RULE_07
      s_taken_commit |=> s_idle_slot)
      else $error("Taken branch idle cycle wrong.");
   AST_NOT_TAKEN: assert property ( // RULE_07
      commit && br_hit && !take |=> (r_reg.st == ST_IDLE) && (r_reg.pc == $past(next_pc)))
      else $error("Untaken branch took extra time.");
   AST_SIGN_SET: assert property ( // RULE_09
      commit && (r_reg.instr[15:8] == OP_BRANCH_ON_SIGN)
      |=> (r_reg.st == ST_NOP) == $past(r_reg.fl.n))
      else $error("Negative branch decision wrong.");
   AST_WRAP_CLEAR: assert property ( // RULE_10
      commit && (r_reg.instr[15:8] == OP_BRANCH_NO_WRAP)
      |=> (r_reg.st == ST_NOP) == !$past(r_reg.fl.wrap))
      else $error("Wrap-clear branch decision wrong.");
   AST_CARRY_SET: assert property ( // RULE_11
      commit && (r_reg.instr[15:8] == OP_BRANCH_ON_CARRY)
      |=> (r_reg.st == ST_NOP) == $past(r_reg.fl.c))
      else $error("Carry branch decision wrong.");
   AST_AND_FLAGS: assert property ( // RULE_12
      commit && is_and_imm |=> (r_reg.wreg == $past(r_reg.wreg & f))
                             && (r_reg.fl.c == $past(r_reg.fl.c))
                             && (r_reg.fl.wrap == $past(r_reg.fl.wrap)))
      else $error("AND literal result or flags wrong.");
endmodule

// >>> tb_byte_alu_and_branch_decode.sv
// Purpose: Self-checking bench for the byte ALU and flag branch decoder.
// Assumes: Registers are reached over APB; results are polled through STATE.
// Notes: No random stimulus; every expectation is worked out here.
`timescale 1ns/1ps
module tb_byte_alu_and_branch_decode;
   import alu_branch_pkg::*;
   // Clock, reset and clock enable.
   logic pclk;
   logic presetn;
   logic ce;
   // APB request and answer.
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   // Score keeping and the hang guard, sized well above the expected run.
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   localparam int LIMIT = 20000;
   // Branch opcodes with a status that takes and one that does not.
   logic [7:0] bop [5] = '{OP_BRANCH_ON_CARRY, OP_BRANCH_NO_CARRY, OP_BRANCH_NO_WRAP,
      OP_BRANCH_ON_SIGN, OP_BRANCH_SIGN_CLEAR};
   logic [4:0] bst_t [5] = '{5'h01, 5'h1E, 5'h17, 5'h10, 5'h0F};
   logic [4:0] bst_n [5] = '{5'h1E, 5'h01, 5'h08, 5'h0F, 5'h10};

   byte_alu_and_branch_decode byte_alu_and_branch_decode_inst (
      .pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // Free running clock, 8 ns period.
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // A hang counts as a mismatch and still ends with the verdict.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         err_total++;
         wrap_up();
      end
   end

   // Compares one data word.
   task automatic chk_data(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         err_total++;
      end
   endtask

   // Compares one status bit.
   task automatic chk_err(input string name, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value %s expected %b seen %b", name, exp, got);
         err_total++;
      end
   endtask

   // One APB transfer; the answer is taken at the rising edge that sees pready high.
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Write that must be accepted.
   task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
      logic [31:0] d;
      logic e;
      apb(1'b1, addr, wd, d, e);
      chk_err("write error", 1'b0, e);
   endtask

   // Read and compare a whole register.
   task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp);
      logic [31:0] d;
      logic e;
      apb(1'b0, addr, 32'h0, d, e);
      chk_data(name, exp, d);
   endtask

   // Issues one instruction; bl is busy as seen between result and idle-slot end.
   task automatic run(input logic [15:0] ins, output logic bl);
      logic [31:0] d;
      logic e;
      int k;
      apb(1'b1, OFF_INSTR, {16'h0000, ins}, d, e);
      repeat (3) @(posedge pclk);
      apb(1'b0, OFF_STATE, 32'h0, d, e);
      bl = d[STATE_BUSY_BIT];
      k = 0;
      while (d[STATE_BUSY_BIT] !== 1'b0 && k < 8) begin
         apb(1'b0, OFF_STATE, 32'h0, d, e);
         k++;
      end
      chk_err("busy cleared", 1'b0, d[STATE_BUSY_BIT]);
   endtask

   // Reference add: flags n, ov, z, dc, c above the sum.
   function automatic logic [12:0] add_ref(logic [7:0] a, logic [7:0] b, logic ci);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
   endfunction

   // Runs one data instruction and checks accumulator, flags, counter and file side.
   task automatic alu(input logic [15:0] ins, input logic [7:0] w, f, input logic [4:0] st,
      input logic [7:0] ew, ef, input logic [4:0] est, input logic [12:0] ea, input logic ca);
      logic [31:0] pc0;
      logic e;
      logic b;
      wr(OFF_WREG, {24'h0, w});
      wr(OFF_FILE_IN, {24'h0, f});
      wr(OFF_STATUS, {27'h0, st});
      apb(1'b0, OFF_PC, 32'h0, pc0, e);
      run(ins, b);
      chk_err("single cycle", 1'b0, b);
      rd_chk("wreg", OFF_WREG, {24'h0, ew});
      rd_chk("status", OFF_STATUS, {27'h0, est});
      rd_chk("pc", OFF_PC, {11'h0, pc0[20:0] + PC_STEP});
      // The file side is only meaningful for forms that address a file register.
      if (ca) begin
         rd_chk("file addr", OFF_FILE_ADDR, {19'h0, ea});
         if (ea[12]) begin
            rd_chk("file out", OFF_FILE_OUT, {24'h0, ef});
         end
      end
   endtask

   // Add forms; wc selects the carry-in form.
   task automatic add_case(input logic wc, d, a, input logic [7:0] fa, w, f,
      input logic [4:0] st, input logic [11:0] adr);
      logic [12:0] r;
      r = add_ref(w, f, wc & st[0]);
      alu({wc ? OP_ADD_WITH_CARRY : OP_ADD_ACC_TO_FILE, d, a, fa}, w, f, st,
         d ? w : r[7:0], r[7:0], r[12:8], {d, adr}, 1'b1);
   endtask

   // Conditional branch; target wraps in the 21-bit counter.
   task automatic br(input logic [7:0] op, input logic [4:0] st, input logic [7:0] n,
      input logic [20:0] pc0, input logic tk);
      logic [31:0] d;
      logic e;
      logic b;
      logic [20:0] ep;
      ep = tk ? pc0 + PC_STEP + {{12{n[7]}}, n, 1'b0} : pc0 + PC_STEP;
      wr(OFF_PC, {11'h0, pc0});
      wr(OFF_STATUS, {27'h0, st});
      run({op, n}, b);
      chk_err("taken busy", tk, b);
      rd_chk("pc", OFF_PC, {11'h0, ep});
      rd_chk("status", OFF_STATUS, {27'h0, st});
      apb(1'b0, OFF_STATE, 32'h0, d, e);
      chk_err("taken flag", tk, d[STATE_TAKEN_BIT]);
   endtask

   // Main sequence.
   initial begin
      logic [31:0] d;
      logic e;
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("ctrl", OFF_CTRL, 32'h0);
      rd_chk("pc", OFF_PC, 32'h0);
      rd_chk("status", OFF_STATUS, 32'h0);
      apb(1'b0, 8'h2C, 32'h0, d, e);
      chk_err("unmapped read error", 1'b1, e);
      chk_data("unmapped read data", 32'h0, d);
      apb(1'b1, 8'h40, 32'hFF, d, e);
      chk_err("unmapped write error", 1'b1, e);
      apb(1'b1, OFF_FILE_OUT, 32'hFF, d, e);
      chk_err("read-only write error", 1'b0, e);
      rd_chk("file out", OFF_FILE_OUT, 32'h0);
      $display("register test done");
      wr(OFF_BANK, 32'h3);
      add_case(1'b0, 1'b0, 1'b1, 8'h45, 8'h17, 8'hC2, 5'h00, 12'h345);
      add_case(1'b1, 1'b1, 1'b0, 8'h20, 8'h4D, 8'h02, 5'h01, 12'h020);
      add_case(1'b0, 1'b1, 1'b0, 8'h80, 8'hFF, 8'h01, 5'h01, 12'hF80);
      add_case(1'b1, 1'b0, 1'b0, 8'h5F, 8'h7F, 8'h00, 5'h01, 12'h05F);
      add_case(1'b1, 1'b1, 1'b1, 8'h0A, 8'h10, 8'h20, 5'h1E, 12'h30A);
      $display("add test done");
      alu({OP_AND_IMMEDIATE, 8'h5F}, 8'hA3, 8'h00, 5'h0B, 8'h03, 8'h00, 5'h0B, 13'h0, 1'b0);
      alu({OP_AND_IMMEDIATE, 8'h80}, 8'h80, 8'h00, 5'h0F, 8'h80, 8'h00, 5'h1B, 13'h0, 1'b0);
      alu({OP_AND_ACC_WITH_FILE, 2'b01, 8'h45}, 8'h17, 8'hC2, 5'h00, 8'h02, 8'h00, 5'h00,
         13'h0345, 1'b1);
      alu({OP_AND_ACC_WITH_FILE, 2'b10, 8'h30}, 8'h0F, 8'hF0, 5'h03, 8'h0F, 8'h00, 5'h07,
         13'h1030, 1'b1);
      alu({OP_CLEAR_FILE_BIT, 3'd7, 1'b0, 8'h30}, 8'h55, 8'hC7, 5'h1F, 8'h55, 8'h47, 5'h1F,
         13'h1030, 1'b1);
      alu({OP_CLEAR_FILE_BIT, 3'd3, 1'b1, 8'h45}, 8'h55, 8'hFF, 5'h00, 8'h55, 8'hF7, 5'h00,
         13'h1345, 1'b1);
      $display("logic test done");
      wr(OFF_CTRL, 32'h1);
      wr(OFF_INDEX, 32'h100);
      add_case(1'b0, 1'b1, 1'b0, 8'h5F, 8'h01, 8'h01, 5'h00, 12'h15F);
      add_case(1'b0, 1'b1, 1'b0, 8'h60, 8'h01, 8'h01, 5'h00, 12'hF60);
      add_case(1'b1, 1'b1, 1'b1, 8'h10, 8'h80, 8'h80, 5'h01, 12'h310);
      wr(OFF_INDEX, 32'hFF0);
      add_case(1'b0, 1'b1, 1'b0, 8'h20, 8'h02, 8'h03, 5'h00, 12'h010);
      wr(OFF_CTRL, 32'h0);
      $display("indexed test done");
      for (int i = 0; i < 5; i++) begin
         br(bop[i], bst_t[i], i[0] ? 8'h80 : 8'h7F, i[0] ? 21'h000010 : 21'h1FFFF0,
            1'b1);
         br(bop[i], bst_n[i], 8'h40, 21'h000100, 1'b0);
      end
      br(8'hE4, 5'h08, 8'h10, 21'h000100, 1'b0);
      br(OP_BRANCH_ON_CARRY, 5'h01, 8'hF0, 21'h000400, 1'b1);
      $display("branch test done");
      // A stalled enable must freeze the taken branch, so writes other than control stay refused.
      wr(OFF_WREG, 32'h11);
      wr(OFF_STATUS, 32'h01);
      apb(1'b1, OFF_INSTR, {16'h0, OP_BRANCH_ON_CARRY, 8'h02}, d, e);
      ce <= 1'b0;
      repeat (20) @(posedge pclk);
      ce <= 1'b1;
      apb(1'b1, OFF_WREG, 32'hAA, d, e);
      chk_err("busy write error", 1'b1, e);
      wr(OFF_CTRL, 32'h0);
      repeat (12) @(posedge pclk);
      rd_chk("wreg", OFF_WREG, 32'h11);
      apb(1'b0, OFF_STATE, 32'h0, d, e);
      chk_err("busy after stall", 1'b0, d[STATE_BUSY_BIT]);
      $display("stall test done");
      wrap_up();
   end
endmodule
